/* hw/period_timer_pkg.sv */
// Constants and register map of the period timer block
package period_timer_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h11;
  localparam logic [7:0] ADDR_CONTROL = 8'h12;
  localparam logic [7:0] ADDR_ENABLES = 8'h8C;
  localparam logic [7:0] ADDR_PERIOD = 8'h92;
  // Values after reset
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [6:0] RST_CONTROL = 7'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  // Field positions
  localparam int CTL_PRE_LSB = 0;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_POST_LSB = 3;
  localparam int FLAG_MATCH_BIT = 1;
  // Instruction clock edge comes at this last phase count, so the system clock is divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  // Prescale select codes
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  // Prescale terminal counts
  localparam logic [3:0] PRE_LAST1 = 4'h0;
  localparam logic [3:0] PRE_LAST4 = 4'h3;
  localparam logic [3:0] PRE_LAST16 = 4'hF;
endpackage

/* hw/period_prescaler.sv */
// Instruction clock divider and 1/4/16 prescaler of the period timer
`timescale 1ns/10ps
module period_prescaler
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic run,
  input wire logic [1:0] prescale_select,
  output logic tick
);
  // All state in one record
  typedef struct packed {
    logic [1:0] phase;
    logic [3:0] count;
  } pre_state_t;
  pre_state_t st_r;
  pre_state_t st_nxt;
  logic [3:0] last;
  logic instr_edge;

  // Terminal count for the selected ratio; 1x both mean sixteen
  always_comb
  begin
    unique case (prescale_select)
      period_timer_pkg::PRE_DIV1: last = period_timer_pkg::PRE_LAST1;
      period_timer_pkg::PRE_DIV4: last = period_timer_pkg::PRE_LAST4;
      default: last = period_timer_pkg::PRE_LAST16;
    endcase
  end

  // Instruction clock edge every fourth system clock
  assign instr_edge = st_r.phase == period_timer_pkg::INSTR_DIV_LAST;
  // A clear in the same cycle swallows the tick so writes land exactly
  assign tick = run && instr_edge && !clear && (st_r.count >= last);

  // Next state; a clear restarts the prescale count, the phase runs on
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.phase = st_r.phase + 2'h1;
    if (clear)
    begin
      st_nxt.count = 4'h0;
    end
    else if (run && instr_edge)
    begin
      // Wrap at the terminal; >= recovers after a ratio change
      st_nxt.count = (st_r.count >= last) ? 4'h0 : st_r.count + 4'h1;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // A tick only when the timer runs
  chk_tick_needs_run: assert property (
    @(posedge clk_sys) disable iff (rst)
    tick |-> run) else $error("tick while stopped");
  // Ticks at one in four clocks at most
  chk_tick_spacing: assert property (
    @(posedge clk_sys) disable iff (rst)
    tick |=> !tick [*3]) else $error("ticks too close");
endmodule

/* hw/period_postscaler.sv */
// Postscaler that divides period matches by one to sixteen
`timescale 1ns/10ps
module period_postscaler
#(
  parameter int WIDTH = 4
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic match,
  input wire logic [WIDTH-1:0] postscale_select,
  output logic event_out
);
  // All state in one record
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } post_state_t;
  post_state_t st_r;
  post_state_t st_nxt;

  // Widths the counter cannot serve are refused at elaboration
  if (WIDTH < 1 || WIDTH > 8)
  begin
    $error("postscaler width out of range");
  end

  // Output when the match count reaches select; ratio is select plus one
  assign event_out = match && !clear && (st_r.count >= postscale_select);

  // Next state
  always_comb
  begin
    st_nxt = st_r;
    if (clear)
      st_nxt.count = '0;
    else if (match)
      st_nxt.count = event_out ? '0 : st_r.count + 1'b1;
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Select zero passes every match
  chk_post_div1: assert property (
    @(posedge clk_sys) disable iff (rst)
    (match && !clear && postscale_select == '0) |-> event_out)
    else $error("divide by one lost a match");
endmodule

/* hw/period_timer.sv */
// Eight-bit period timer with prescaler, postscaler and interrupt
`timescale 1ns/10ps
module period_timer
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic sync_serial_port_tick,
  output logic pwm_match,
  output logic [7:0] pwm_timer_count
);
  // The instruction clock is one system clock in four and the prescaler
  // turns it into count ticks. A tick that finds the count equal to the
  // period wraps it to zero and issues a match, which leaves on the serial
  // and PWM ports one cycle later. Count and control writes win over the counter in
  // the same cycle and stop both scalers from ticking, so a written value
  // is exactly what reads back. The price is that a write right at a tick
  // swallows that tick; software that keeps writing may slow the timer.

  // All state in one record
  typedef struct packed {
    logic [7:0] timer_count;
    logic [7:0] period_value;
    logic [6:0] timer_control;
    logic match_interrupt_flag;
    logic match_interrupt_enable;
    logic [7:0] rdata;
    logic ssp_tick;
  } timer_state_t;
  timer_state_t st_r;
  timer_state_t st_nxt;

  logic wr_count;
  logic wr_control;
  logic wr_flags;
  logic wr_enables;
  logic wr_period;
  logic scaler_clear;
  logic pre_tick;
  logic at_period;
  logic match;
  logic post_event;
  logic [7:0] read_mux;

  // Decode one register address against a strobe
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off,
                               input logic strobe);
    hit = strobe && (addr == off);
  endfunction

  // Write decode
  assign wr_count = hit(reg_addr, period_timer_pkg::ADDR_COUNT, reg_write);
  assign wr_control = hit(reg_addr, period_timer_pkg::ADDR_CONTROL,
                          reg_write);
  assign wr_flags = hit(reg_addr, period_timer_pkg::ADDR_FLAGS, reg_write);
  assign wr_enables = hit(reg_addr, period_timer_pkg::ADDR_ENABLES,
                          reg_write);
  assign wr_period = hit(reg_addr, period_timer_pkg::ADDR_PERIOD, reg_write);

  // Both scaler chains restart on count or control writes
  assign scaler_clear = wr_count || wr_control;

  // Prescaled instruction clock
  period_prescaler u_pre
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(scaler_clear),
    .run(st_r.timer_control[period_timer_pkg::CTL_RUN_BIT]),
    .prescale_select(st_r.timer_control[period_timer_pkg::CTL_PRE_LSB +: 2]),
    .tick(pre_tick)
  );

  // Match is the wrap increment; a software count write takes precedence
  assign at_period = st_r.timer_count == st_r.period_value;
  assign match = pre_tick && at_period && !wr_count;

  // Postscaler on the match stream
  period_postscaler #(.WIDTH(4)) u_post
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(scaler_clear),
    .match(match),
    .postscale_select(
      st_r.timer_control[period_timer_pkg::CTL_POST_LSB +: 4]),
    .event_out(post_event)
  );

  // Read multiplexer; unmapped addresses read zero
  always_comb
  begin
    read_mux = 8'h00;
    unique case (reg_addr)
      period_timer_pkg::ADDR_COUNT: read_mux = st_r.timer_count;
      period_timer_pkg::ADDR_PERIOD: read_mux = st_r.period_value;
      // Bit 7 unimplemented, reads zero
      period_timer_pkg::ADDR_CONTROL: read_mux = {1'b0, st_r.timer_control};
      period_timer_pkg::ADDR_FLAGS:
        read_mux[period_timer_pkg::FLAG_MATCH_BIT] = st_r.match_interrupt_flag;
      period_timer_pkg::ADDR_ENABLES:
        read_mux[period_timer_pkg::FLAG_MATCH_BIT] =
          st_r.match_interrupt_enable;
      default: read_mux = 8'h00;
    endcase
  end

  // Next state of the timer and its registers
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ssp_tick = match;
    st_nxt.rdata = reg_read ? read_mux : 8'h00;
    // Counter: software write wins over the increment
    if (wr_count)
      st_nxt.timer_count = reg_wdata;
    else if (pre_tick)
      st_nxt.timer_count = at_period ? 8'h00 : st_r.timer_count + 8'h01;
    // Control write keeps the count as it is
    if (wr_control)
      st_nxt.timer_control = reg_wdata[6:0];
    if (wr_period)
      st_nxt.period_value = reg_wdata;
    if (wr_enables)
      st_nxt.match_interrupt_enable =
        reg_wdata[period_timer_pkg::FLAG_MATCH_BIT];
    // Write one clears; a coincident event wins
    if (wr_flags && reg_wdata[period_timer_pkg::FLAG_MATCH_BIT])
      st_nxt.match_interrupt_flag = 1'b0;
    if (post_event)
      st_nxt.match_interrupt_flag = 1'b1;
  end

  // State register with documented reset values
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r.timer_count <= period_timer_pkg::RST_COUNT;
      st_r.period_value <= period_timer_pkg::RST_PERIOD;
      st_r.timer_control <= period_timer_pkg::RST_CONTROL;
      st_r.match_interrupt_flag <= 1'b0;
      st_r.match_interrupt_enable <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.ssp_tick <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs
  assign reg_rdata = st_r.rdata;
  assign irq = st_r.match_interrupt_flag &&
               st_r.match_interrupt_enable;
  assign sync_serial_port_tick = st_r.ssp_tick;
  assign pwm_timer_count = st_r.timer_count;
  assign pwm_match = st_r.ssp_tick;

  // Counter checks
  // Wrap to zero after the period match
  chk_wrap_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pre_tick && at_period && !wr_count) |=> st_r.timer_count == 8'h00)
    else $error("count did not wrap");
  // One step up on a tick below the period
  chk_count_step: assert property (
    @(posedge clk_sys) disable iff (rst)
    (pre_tick && !at_period && !wr_count)
    |=> st_r.timer_count == $past(st_r.timer_count) + 8'h01)
    else $error("count did not step");
  // Without a tick or a write the count holds
  chk_count_idle: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!pre_tick && !wr_count) |=> $stable(st_r.timer_count))
    else $error("count moved without a tick");
  // Stopped timer holds its count
  chk_stop_holds: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!st_r.timer_control[period_timer_pkg::CTL_RUN_BIT] && !wr_count)
    |=> $stable(st_r.timer_count))
    else $error("count moved while stopped");
  // Control write leaves the count alone, even at a tick
  chk_ctl_keeps: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_control |=> st_r.timer_count == $past(st_r.timer_count))
    else $error("control write changed count");
  // Count write lands
  chk_count_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_count |=> st_r.timer_count == $past(reg_wdata))
    else $error("count write lost");

  // Register write checks
  // Period write lands
  chk_period_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_period |=> st_r.period_value == $past(reg_wdata))
    else $error("period write lost");
  // Period changes only by a write
  chk_period_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !wr_period |=> $stable(st_r.period_value))
    else $error("period changed unwritten");
  // Control write lands in the seven implemented bits
  chk_ctl_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_control |=> st_r.timer_control == $past(reg_wdata[6:0]))
    else $error("control write lost");
  // Control changes only by a write
  chk_ctl_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !wr_control |=> $stable(st_r.timer_control))
    else $error("control changed unwritten");
  // Enable write lands
  chk_enable_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_enables |=> st_r.match_interrupt_enable ==
      $past(reg_wdata[period_timer_pkg::FLAG_MATCH_BIT]))
    else $error("enable write lost");
  // Enable changes only by a write
  chk_enable_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !wr_enables |=> $stable(st_r.match_interrupt_enable))
    else $error("enable changed unwritten");

  // Read port checks
  // Count read returns the count of the strobe cycle
  chk_read_count: assert property (
    @(posedge clk_sys) disable iff (rst)
    (reg_read && reg_addr == period_timer_pkg::ADDR_COUNT)
    |=> reg_rdata == $past(st_r.timer_count))
    else $error("count read wrong");
  // Period read returns the period
  chk_read_period: assert property (
    @(posedge clk_sys) disable iff (rst)
    (reg_read && reg_addr == period_timer_pkg::ADDR_PERIOD)
    |=> reg_rdata == $past(st_r.period_value))
    else $error("period read wrong");
  // Flag read shows only the match flag bit
  chk_read_flag: assert property (
    @(posedge clk_sys) disable iff (rst)
    (reg_read && reg_addr == period_timer_pkg::ADDR_FLAGS)
    |=> reg_rdata == {6'h00, $past(st_r.match_interrupt_flag), 1'h0})
    else $error("flag read wrong");
  // Enable read shows only the match enable bit
  chk_read_enable: assert property (
    @(posedge clk_sys) disable iff (rst)
    (reg_read && reg_addr == period_timer_pkg::ADDR_ENABLES)
    |=> reg_rdata == {6'h00, $past(st_r.match_interrupt_enable), 1'h0})
    else $error("enable read wrong");

  // Flag checks
  // Flag stays set until written one
  chk_flag_sticky: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_r.match_interrupt_flag &&
     !(wr_flags && reg_wdata[period_timer_pkg::FLAG_MATCH_BIT]))
    |=> st_r.match_interrupt_flag) else $error("flag dropped");
  // Postscaled event raises the flag
  chk_flag_set: assert property (
    @(posedge clk_sys) disable iff (rst)
    post_event |=> st_r.match_interrupt_flag)
    else $error("flag not set");
  // Writing one clears the flag when no event coincides
  chk_flag_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    (wr_flags && reg_wdata[period_timer_pkg::FLAG_MATCH_BIT] && !post_event)
    |=> !st_r.match_interrupt_flag)
    else $error("flag not cleared");
  // Only a postscaled event sets the flag
  chk_flag_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!st_r.match_interrupt_flag && !post_event)
    |=> !st_r.match_interrupt_flag)
    else $error("flag set without event");
  // A stopped timer raises no event
  chk_post_stopped: assert property (
    @(posedge clk_sys) disable iff (rst)
    !st_r.timer_control[period_timer_pkg::CTL_RUN_BIT] |-> !post_event)
    else $error("event while stopped");

  // Match output checks
  // Serial port tick follows the match by one cycle
  chk_ssp_tick: assert property (
    @(posedge clk_sys) disable iff (rst)
    match |=> sync_serial_port_tick)
    else $error("serial tick missing");
  // Serial port tick is a single-cycle pulse
  chk_ssp_pulse: assert property (
    @(posedge clk_sys) disable iff (rst)
    sync_serial_port_tick |=> !sync_serial_port_tick)
    else $error("serial tick too long");
  // The PWM match pulse stands while the count has wrapped
  chk_ssp_at_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    pwm_match |-> pwm_timer_count == 8'h00)
    else $error("match pulse off zero");
  // No postscaled event right after a scaler clear unless ratio one
  chk_clear_scaler: assert property (
    @(posedge clk_sys) disable iff (rst)
    (wr_control && reg_wdata[6:3] != 4'h0) |=> !post_event)
    else $error("postscaler not cleared");
endmodule

/* test/period_timer_tb.sv */
// Self-checking testbench of the period timer block
`timescale 1ns/10ps
module period_timer_tb;
  logic clk_sys = 1'b0; // 20 MHz system clock
  logic rst = 1'b1; // Held high at start
  logic [7:0] reg_addr = 8'h00; // Register address
  logic [7:0] reg_wdata = 8'h00; // Write data
  logic reg_write = 1'b0; // Write strobe
  logic reg_read = 1'b0; // Read strobe
  logic [7:0] reg_rdata; // Read data, one cycle after strobe
  logic irq; // Interrupt level
  logic sync_serial_port_tick; // Match pulse to serial port
  logic pwm_match; // Match pulse to PWM unit
  logic [7:0] pwm_timer_count; // Live count
  int n_errors = 0; // Mismatches seen
  int checks_done = 0; // Comparisons made
  int gap; // Cycles between count changes
  int m; // Match pulses counted
  int n; // Bounded wait counter
  int ratio[4] = '{1, 2, 5, 16}; // Postscale ratios tried

  // Half period of 25 ns gives 50 ns
  always #25 clk_sys = ~clk_sys;

  period_timer dut_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq),
    .sync_serial_port_tick(sync_serial_port_tick),
    .pwm_match(pwm_match), .pwm_timer_count(pwm_timer_count));

  // Compare and report one value
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  // One-cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    chk(what, exp, reg_rdata);
  endtask

  // Cycles until the count moves, sampled mid-cycle to avoid races
  task automatic wait_change(output int k);
    logic [7:0] was;
    k = 0;
    @(negedge clk_sys);
    was = pwm_timer_count;
    while (pwm_timer_count === was && k < 300)
    begin
      @(negedge clk_sys);
      k++;
    end
    // A count that never moves is a mismatch by itself
    if (k >= 300)
    begin
      n_errors++;
      $display("[FAIL] count change expected within 300 seen none");
    end
  endtask

  // Verdict and end of run, shared with the watchdog
  task automatic wrap_up;
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Both match outputs must always agree
  always @(negedge clk_sys)
    if (!rst && sync_serial_port_tick !== pwm_match)
    begin
      n_errors++;
      $display("[FAIL] tick expected %b seen %b", pwm_match,
               sync_serial_port_tick);
    end

  // Run takes about a thousand cycles; far longer means a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    wrap_up();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(period_timer_pkg::ADDR_COUNT, 8'h00, "count");
    rd(period_timer_pkg::ADDR_PERIOD, 8'hFF, "period");
    rd(period_timer_pkg::ADDR_CONTROL, 8'h00, "control");
    rd(period_timer_pkg::ADDR_FLAGS, 8'h00, "flags");
    rd(period_timer_pkg::ADDR_ENABLES, 8'h00, "enables");
    rd(8'h55, 8'h00, "unmapped");
    wr(period_timer_pkg::ADDR_PERIOD, 8'h3C);
    rd(period_timer_pkg::ADDR_PERIOD, 8'h3C, "period rw");
    wr(period_timer_pkg::ADDR_CONTROL, 8'hFF);
    rd(period_timer_pkg::ADDR_CONTROL, 8'h7F, "control rw");
    // Stopped timer: control write must not touch the count
    wr(period_timer_pkg::ADDR_CONTROL, 8'h00);
    wr(period_timer_pkg::ADDR_COUNT, 8'h5A);
    wr(period_timer_pkg::ADDR_CONTROL, 8'h78);
    rd(period_timer_pkg::ADDR_COUNT, 8'h5A, "count kept");
    repeat (100) @(posedge clk_sys);
    rd(period_timer_pkg::ADDR_COUNT, 8'h5A, "count frozen");
    // Every prescale code; second gap avoids the free phase offset
    wr(period_timer_pkg::ADDR_PERIOD, 8'hFF);
    for (int c = 0; c < 4; c++)
    begin
      wr(period_timer_pkg::ADDR_CONTROL, {5'h00, 1'b1, c[1:0]});
      wait_change(gap);
      wait_change(gap);
      chk("prescale gap", (c == 0) ? 8'h03 : (c == 1) ? 8'h0F : 8'h3F,
          8'(gap));
    end
    // Count write mid-prescale restarts the divide by 16
    repeat (30) @(posedge clk_sys);
    wr(period_timer_pkg::ADDR_COUNT, 8'h10);
    wait_change(gap);
    chk("scaler clear", 8'h01, {7'h00, gap >= 58 && gap <= 64});
    chk("count after write", 8'h11, pwm_timer_count);
    // Wrap at period two with the match pulse in the same cycle as the wrapped count
    wr(period_timer_pkg::ADDR_CONTROL, 8'h00);
    wr(period_timer_pkg::ADDR_COUNT, 8'h00);
    wr(period_timer_pkg::ADDR_PERIOD, 8'h02);
    wr(period_timer_pkg::ADDR_CONTROL, 8'h04);
    wait_change(gap);
    chk("count up", 8'h01, pwm_timer_count);
    wait_change(gap);
    chk("count at period", 8'h02, pwm_timer_count);
    wait_change(gap);
    chk("count wrap", 8'h00, pwm_timer_count);
    m = int'(pwm_match === 1'b1);
    @(negedge clk_sys);
    m += int'(pwm_match === 1'b1);
    chk("match pulses", 8'h01, 8'(m));
    // Postscale ratios: flag rises on the n-th match
    wr(period_timer_pkg::ADDR_PERIOD, 8'h01);
    wr(period_timer_pkg::ADDR_ENABLES, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      wr(period_timer_pkg::ADDR_CONTROL, 8'h00);
      wr(period_timer_pkg::ADDR_FLAGS, 8'h02);
      wr(period_timer_pkg::ADDR_COUNT, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk("irq cleared", 8'h00, {7'h00, irq});
      wr(period_timer_pkg::ADDR_CONTROL, {1'b0, 4'(ratio[i] - 1), 3'h4});
      m = 0;
      n = 0;
      while (irq !== 1'b1 && n < 400)
      begin
        @(negedge clk_sys);
        m += int'(pwm_match === 1'b1);
        n++;
      end
      repeat (3) @(negedge clk_sys) m += int'(pwm_match === 1'b1);
      chk("postscale", 8'(ratio[i]), 8'(m));
      rd(period_timer_pkg::ADDR_FLAGS, 8'h02, "flag set");
    end
    // Mask, sticky flag, write-one clear
    wr(period_timer_pkg::ADDR_ENABLES, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(period_timer_pkg::ADDR_CONTROL, 8'h00);
    wr(period_timer_pkg::ADDR_FLAGS, 8'h00);
    rd(period_timer_pkg::ADDR_FLAGS, 8'h02, "flag sticky");
    wr(period_timer_pkg::ADDR_ENABLES, 8'h02);
    repeat (2) @(negedge clk_sys);
    chk("irq unmasked", 8'h01, {7'h00, irq});
    wr(period_timer_pkg::ADDR_FLAGS, 8'h02);
    rd(period_timer_pkg::ADDR_FLAGS, 8'h00, "flag cleared");
    chk("irq off", 8'h00, {7'h00, irq});
    // Reset in mid-run puts count, period and control back
    wr(period_timer_pkg::ADDR_PERIOD, 8'h33);
    wr(period_timer_pkg::ADDR_COUNT, 8'h44);
    wr(period_timer_pkg::ADDR_CONTROL, 8'h06);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(period_timer_pkg::ADDR_COUNT, 8'h00, "count reset");
    rd(period_timer_pkg::ADDR_PERIOD, 8'hFF, "period reset");
    rd(period_timer_pkg::ADDR_CONTROL, 8'h00, "ctl reset");
    chk("irq reset", 8'h00, {7'h00, irq});
    wrap_up();
  end
endmodule
